// [logic/muxed_port_pkg.sv]
package muxed_port_pkg;
    localparam int ADDR_W = 16;
    localparam int BYTE_W = 8;
    localparam int EPROM_ADDR_W = 15;
    localparam int EPROM_SEL_BIT = 15;
    localparam int BLOCK_W = 5;
    localparam int BLOCK_LSB = 11;
    localparam int OFFSET_W = 5;
    localparam int GAP_LSB = 5;
    localparam int GAP_W = 6;
    localparam logic [GAP_W-1:0] GAP_ZERO = 6'h00;
    localparam logic [BLOCK_W-1:0] DEFAULT_BLOCK = 5'h1f;
    localparam logic [OFFSET_W-1:0] OFF_LATCH1 = 5'h00;
    localparam logic [OFFSET_W-1:0] OFF_LATCH2 = 5'h01;
    localparam logic [OFFSET_W-1:0] OFF_PIN1 = 5'h08;
    localparam logic [OFFSET_W-1:0] OFF_PIN2 = 5'h09;
    localparam logic [OFFSET_W-1:0] OFF_PLANE_SEL = 5'h10;
    localparam logic [BYTE_W-1:0] LATCH_RESET = 8'hff;
    localparam logic [BYTE_W-1:0] PLANE_SEL_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] READ_ZERO = 8'h00;
    localparam logic [1:0] PLANE_PROG_EPROM = 2'h1;
    localparam logic [1:0] PLANE_PROG_CONFIG = 2'h2;
    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_ADDR = 2'h1,
        PH_DATA = 2'h3
    } phase_t;
endpackage

// [logic/port_unit.sv]
`timescale 1ns/1ps
module port_unit #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic set_ones_in,
    input wire logic write_in,
    input wire logic [WIDTH-1:0] write_data_in,
    input wire logic push_pull_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] latch_out,
    output logic [WIDTH-1:0] pin_level_out,
    output logic [WIDTH-1:0] pin_oe_out
);
    import muxed_port_pkg::*;

    logic [WIDTH-1:0] next_latch;

    always_comb begin
        next_latch = latch_out;
        if (set_ones_in) begin
            next_latch = {WIDTH{1'b1}};
        end else if (write_in) begin
            next_latch = write_data_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            latch_out <= {WIDTH{1'b1}};
        end else begin
            latch_out <= next_latch;
        end
    end

    // A pin is never turned around; a one in the latch lets the pull-up win unless push_pull_in drives it high.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_oe_out <= '0;
        end else begin
            pin_oe_out <= ~next_latch | {WIDTH{push_pull_in}};
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_level_out <= '0;
        end else begin
            pin_level_out <= pin_in;
        end
    end
endmodule

// [logic/muxed_bus_port_expander.sv]
// Summary of operation
// - All sixteen address inputs are captured while the latch enable strobe is high.
// - Low address byte and data share eight pins in separate access phases.
// - EPROM data is driven only while the program read strobe is asserted, or either read strobe in single-plane mode.
// - Special register data is driven only while the read strobe is asserted, or either read strobe in single-plane mode.
// - Special register writes happen only under the write/program strobe.
// - Chip enable qualifies every access to every plane.
// - Active reset in operating mode sets both port latches to all ones.
// - Two 8-bit ports, each with its own latch and pin address.
// - Ports are always outputs; writing ones lets a pin serve as input unless push-pull drive is enabled for its port.
// - Reading a latch location returns the value last written.
// - Reading a pin location returns the levels on the external pins.
// - The 32K EPROM sits in the lower or upper half by configuration.
// - Dual-plane mode or configurable single shared plane.
// - Exactly five special registers: two latches, two pins, plane select.
// - Plane select steers programming to EPROM or configuration registers.
// - Configuration picks active-high or active-low reset input.
// - Configuration relocates the special register block.
// - Per-port configuration enables active pull-up drive.
// - Plane select 01 programs EPROM, 10 configuration, 00 or 11 nothing.
// - Special block is the low 32 bytes of a 2K region on any 2K boundary, default top.
// - Block locations 0 and 1 are latches, 8 and 9 are pins.
`timescale 1ns/1ps
module muxed_bus_port_expander #(
    parameter int PORT_W = 8
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic addr_latch_en_in,
    input wire logic [muxed_port_pkg::BYTE_W-1:0] addr_hi_in,
    input wire logic [muxed_port_pkg::BYTE_W-1:0] ad_in,
    output logic [muxed_port_pkg::BYTE_W-1:0] ad_out,
    output logic ad_oe_out,
    input wire logic program_read_strobe_n_in,
    input wire logic read_strobe_n_in,
    input wire logic write_program_strobe_n_in,
    input wire logic chip_enable_n_in,
    input wire logic reset_pin_in,
    input wire logic program_mode_in,
    input wire logic cfg_reset_active_low_in,
    input wire logic cfg_eprom_upper_in,
    input wire logic cfg_single_plane_in,
    input wire logic [muxed_port_pkg::BLOCK_W-1:0] cfg_block_base_in,
    input wire logic cfg_port1_push_pull_in,
    input wire logic cfg_port2_push_pull_in,
    input wire logic [PORT_W-1:0] port1_pin_in,
    output logic [PORT_W-1:0] port1_pin_out,
    output logic [PORT_W-1:0] port1_pin_oe_out,
    input wire logic [PORT_W-1:0] port2_pin_in,
    output logic [PORT_W-1:0] port2_pin_out,
    output logic [PORT_W-1:0] port2_pin_oe_out,
    output logic config_write_out,
    output logic [muxed_port_pkg::ADDR_W-1:0] config_addr_out,
    output logic [muxed_port_pkg::BYTE_W-1:0] config_data_out
);
    import muxed_port_pkg::*;

    localparam int EPROM_DEPTH = 1 << EPROM_ADDR_W;

    phase_t phase;
    phase_t next_phase;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] plane_sel;
    logic [BYTE_W-1:0] eprom [EPROM_DEPTH];
    logic [BYTE_W-1:0] eprom_word;
    logic [BYTE_W-1:0] write_data;
    logic write_seen;
    logic write_commit;
    logic reset_active;
    logic chip_en;
    logic eprom_hit;
    logic block_hit;
    logic [OFFSET_W-1:0] offset;
    logic eprom_rd;
    logic block_rd;
    logic next_oe;
    logic [BYTE_W-1:0] block_rdata;
    logic [BYTE_W-1:0] next_ad;
    logic latch1_we;
    logic latch2_we;
    logic plane_sel_we;
    logic eprom_we;
    logic config_we;
    logic [PORT_W-1:0] latch1;
    logic [PORT_W-1:0] latch2;
    logic [PORT_W-1:0] pin1;
    logic [PORT_W-1:0] pin2;

    assign chip_en = !chip_enable_n_in;
    assign reset_active = cfg_reset_active_low_in ? !reset_pin_in : reset_pin_in;

    always_comb begin
        next_phase = phase;
        case (phase)
            PH_IDLE: begin
                if (addr_latch_en_in) begin
                    next_phase = PH_ADDR;
                end
            end
            PH_ADDR: begin
                if (!addr_latch_en_in) begin
                    next_phase = PH_DATA;
                end
            end
            PH_DATA: begin
                if (addr_latch_en_in) begin
                    next_phase = PH_ADDR;
                end
            end
            default: begin
                next_phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase <= PH_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            addr <= '0;
        end else if (addr_latch_en_in) begin
            addr <= {addr_hi_in, ad_in};
        end
    end

    assign eprom_hit = addr[EPROM_SEL_BIT] == cfg_eprom_upper_in;
    // Only the low 32 bytes of the 2K block decode; the rest of the block falls through to the EPROM or is not driven.
    assign block_hit = (addr[ADDR_W-1:BLOCK_LSB] == cfg_block_base_in)
        && (addr[GAP_LSB +: GAP_W] == GAP_ZERO);
    assign offset = addr[OFFSET_W-1:0];
    assign eprom_word = eprom[addr[EPROM_ADDR_W-1:0]];

    always_comb begin
        eprom_rd = 1'b0;
        block_rd = 1'b0;
        if (cfg_single_plane_in) begin
            // In one shared plane either read strobe works and the block shadows the EPROM.
            block_rd = (!program_read_strobe_n_in || !read_strobe_n_in) && block_hit;
            eprom_rd = (!program_read_strobe_n_in || !read_strobe_n_in)
                && eprom_hit && !block_hit;
        end else begin
            eprom_rd = !program_read_strobe_n_in && eprom_hit;
            block_rd = !read_strobe_n_in && block_hit;
        end
    end

    always_comb begin
        case (offset)
            OFF_LATCH1: block_rdata = latch1;
            OFF_LATCH2: block_rdata = latch2;
            OFF_PIN1: block_rdata = pin1;
            OFF_PIN2: block_rdata = pin2;
            OFF_PLANE_SEL: block_rdata = plane_sel;
            default: block_rdata = READ_ZERO;
        endcase
    end

    assign next_oe = chip_en && (phase == PH_DATA) && !addr_latch_en_in
        && (eprom_rd || block_rd);
    assign next_ad = block_rd ? block_rdata : (eprom_rd ? eprom_word : READ_ZERO);

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ad_oe_out <= 1'b0;
            ad_out <= READ_ZERO;
        end else begin
            ad_oe_out <= next_oe;
            ad_out <= next_oe ? next_ad : READ_ZERO;
        end
    end

    // Data is held from the low phase and committed on the rising edge of the strobe,
    // so untouched latch bits never glitch.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            write_seen <= 1'b0;
            write_data <= READ_ZERO;
        end else if (chip_en && phase == PH_DATA && !write_program_strobe_n_in) begin
            write_seen <= 1'b1;
            write_data <= ad_in;
        end else if (write_program_strobe_n_in || !chip_en) begin
            write_seen <= 1'b0;
        end
    end

    assign write_commit = write_seen && write_program_strobe_n_in && chip_en;
    assign latch1_we = write_commit && block_hit && offset == OFF_LATCH1;
    assign latch2_we = write_commit && block_hit && offset == OFF_LATCH2;
    assign plane_sel_we = write_commit && block_hit && offset == OFF_PLANE_SEL;
    assign eprom_we = write_commit && program_mode_in && !block_hit && eprom_hit
        && plane_sel[1:0] == PLANE_PROG_EPROM;
    assign config_we = write_commit && program_mode_in && !block_hit
        && plane_sel[1:0] == PLANE_PROG_CONFIG;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            plane_sel <= PLANE_SEL_RESET;
        end else if (plane_sel_we) begin
            plane_sel <= write_data;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (eprom_we) begin
            eprom[addr[EPROM_ADDR_W-1:0]] <= write_data;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            config_write_out <= 1'b0;
            config_addr_out <= '0;
            config_data_out <= READ_ZERO;
        end else begin
            config_write_out <= config_we;
            if (config_we) begin
                config_addr_out <= addr;
                config_data_out <= write_data;
            end
        end
    end

    port_unit #(.WIDTH(PORT_W)) port1_unit (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .set_ones_in(reset_active && !program_mode_in),
        .write_in(latch1_we),
        .write_data_in(write_data),
        .push_pull_in(cfg_port1_push_pull_in),
        .pin_in(port1_pin_in),
        .latch_out(latch1),
        .pin_level_out(pin1),
        .pin_oe_out(port1_pin_oe_out)
    );

    port_unit #(.WIDTH(PORT_W)) port2_unit (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .set_ones_in(reset_active && !program_mode_in),
        .write_in(latch2_we),
        .write_data_in(write_data),
        .push_pull_in(cfg_port2_push_pull_in),
        .pin_in(port2_pin_in),
        .latch_out(latch2),
        .pin_level_out(pin2),
        .pin_oe_out(port2_pin_oe_out)
    );

    assign port1_pin_out = latch1;
    assign port2_pin_out = latch2;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    addr_capture_a: assert property (addr_latch_en_in |=>
        addr[ADDR_W-1:BYTE_W] == $past(addr_hi_in) && addr[BYTE_W-1:0] == $past(ad_in))
        else $error("address not captured under latch enable");
    addr_phase_a: assert property (addr_latch_en_in |=> !ad_oe_out)
        else $error("data driven during address phase");
    eprom_read_a: assert property ((next_oe && eprom_rd && !block_rd)
        |=> ad_oe_out && ad_out == $past(eprom_word))
        else $error("EPROM byte not returned");
    block_read_a: assert property ((next_oe && block_rd)
        |=> ad_oe_out && ad_out == $past(block_rdata))
        else $error("special register byte not returned");
    chip_gate_a: assert property (chip_enable_n_in |=> !ad_oe_out && !config_write_out)
        else $error("access answered without chip enable");
    reset_ones_a: assert property ((reset_active && !program_mode_in)
        |=> latch1 == LATCH_RESET && latch2 == LATCH_RESET)
        else $error("port latches not set by reset");
    latch_write_a: assert property ((latch1_we && !reset_active)
        |=> latch1 == $past(write_data) && port1_pin_out == $past(write_data))
        else $error("latch did not take written value");
    latch_hold_a: assert property ((!latch2_we && !(reset_active && !program_mode_in))
        |=> $stable(latch2))
        else $error("latch changed without a write");
    plane_decode_a: assert property (config_write_out |->
        $past(plane_sel[1:0]) == PLANE_PROG_CONFIG)
        else $error("configuration written under wrong plane select");
    strobe_commit_a: assert property ($rose(write_program_strobe_n_in) && !write_seen
        |-> !latch1_we && !eprom_we)
        else $error("write committed without a strobe");
endmodule

// [dv/host_bus_model.sv]
`timescale 1ns/1ps
module host_bus_model (
    input wire logic clk_in,
    input wire logic [7:0] data_in,
    input wire logic data_oe_in,
    output logic ale_out,
    output logic [7:0] addr_hi_out,
    output logic [7:0] ad_out,
    output logic prog_rd_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic ce_n_out
);
    initial begin
        ale_out = 1'b0;
        addr_hi_out = 8'h00;
        ad_out = 8'h00;
        prog_rd_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        ce_n_out = 1'b1;
    end

    // Kind 0 writes, 1 reads by the register strobe, 2 by the program strobe.
    task automatic access(input int kind, input logic [15:0] addr, input logic [7:0] wdata,
            input logic ce_on, output logic [7:0] rdata, output logic seen);
        rdata = 8'h00;
        seen = 1'b0;
        @(negedge clk_in);
        ce_n_out = ~ce_on;
        ale_out = 1'b1;
        addr_hi_out = addr[15:8];
        ad_out = addr[7:0];
        @(negedge clk_in);
        ale_out = 1'b0;
        // A read hands the shared pins over, so no stale address may linger there.
        ad_out = (kind == 0) ? wdata : ~addr[7:0];
        @(negedge clk_in);
        wr_n_out = (kind != 0);
        rd_n_out = (kind != 1);
        prog_rd_n_out = (kind != 2);
        repeat (4) begin
            @(posedge clk_in);
            #1;
            if (kind != 0 && !seen && data_oe_in === 1'b1) begin
                seen = 1'b1;
                rdata = data_in;
            end
        end
        @(negedge clk_in);
        wr_n_out = 1'b1;
        rd_n_out = 1'b1;
        prog_rd_n_out = 1'b1;
        repeat (2) @(negedge clk_in);
        ce_n_out = 1'b1;
        ad_out = ~ad_out;
    endtask
endmodule

// [dv/test_muxed_bus_port_expander.sv]
`timescale 1ns/1ps
module test_muxed_bus_port_expander;
    import muxed_port_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic rst_pin = 1'b0;
    logic prog = 1'b0;
    logic rst_low = 1'b0;
    logic upper = 1'b0;
    logic single = 1'b0;
    logic [4:0] base = DEFAULT_BLOCK;
    logic pp1 = 1'b0;
    logic pp2 = 1'b0;
    logic [7:0] ext1 = 8'h5a;
    logic [7:0] ext2 = 8'ha5;
    wire ale, prs_n, rd_n, wr_n, ce_n, oe, cfg_wr;
    wire [7:0] hi, ad, dout, p1, p1_oe, p2, p2_oe, pin1, pin2, cfg_data;
    wire [15:0] cfg_addr;
    logic [7:0] rdata, eprom_val, wdat, psel;
    logic [7:0] lat [2];
    logic [4:0] unused [4] = '{5'h02, 5'h0a, 5'h11, 5'h1f};
    logic [1:0] codes [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
    logic seen;
    int unsigned seed;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    int pulses = 0;
    int n;

    // Pins read back what the port drives, else the external level.
    assign pin1 = (p1_oe & p1) | (~p1_oe & ext1);
    assign pin2 = (p2_oe & p2) | (~p2_oe & ext2);
    always #20 clk = ~clk;

    host_bus_model u_host (.clk_in(clk), .data_in(dout), .data_oe_in(oe), .ale_out(ale),
        .addr_hi_out(hi), .ad_out(ad), .prog_rd_n_out(prs_n), .rd_n_out(rd_n),
        .wr_n_out(wr_n), .ce_n_out(ce_n));

    muxed_bus_port_expander i_dut (.core_clk_in(clk), .reset_n_in(reset_n),
        .addr_latch_en_in(ale), .addr_hi_in(hi), .ad_in(ad), .ad_out(dout), .ad_oe_out(oe),
        .program_read_strobe_n_in(prs_n), .read_strobe_n_in(rd_n),
        .write_program_strobe_n_in(wr_n), .chip_enable_n_in(ce_n), .reset_pin_in(rst_pin),
        .program_mode_in(prog), .cfg_reset_active_low_in(rst_low), .cfg_eprom_upper_in(upper),
        .cfg_single_plane_in(single), .cfg_block_base_in(base), .cfg_port1_push_pull_in(pp1),
        .cfg_port2_push_pull_in(pp2), .port1_pin_in(pin1), .port1_pin_out(p1),
        .port1_pin_oe_out(p1_oe), .port2_pin_in(pin2), .port2_pin_out(p2),
        .port2_pin_oe_out(p2_oe), .config_write_out(cfg_wr), .config_addr_out(cfg_addr),
        .config_data_out(cfg_data));

    task automatic give_verdict();
        if (miscompares == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] ra(input logic [4:0] off);
        return {base, 6'h00, off};
    endfunction

    function automatic logic [7:0] pin_exp(input logic [7:0] l, input logic pp, input logic [7:0] e);
        return pp ? l : (l & e);
    endfunction

    task automatic acc(input int kind, input logic [15:0] a, input logic [7:0] d, input logic ce);
        u_host.access(kind, a, d, ce, rdata, seen);
    endtask

    // An undriven bus reads as zero, so one compare covers data and drive.
    task automatic rd(input int kind, input logic [15:0] a, input logic [7:0] e, input logic s);
        acc(kind, a, 8'h00, 1'b1);
        check({7'h00, seen, rdata}, {7'h00, s, e});
    endtask

    // Counted on the falling edge so the pulse is seen settled, not at its launching edge.
    always @(negedge clk) begin
        cycles++;
        if (cfg_wr === 1'b1) pulses++;
        if (cycles == 3000) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        seed = $urandom(32'h0979);
        repeat (8) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        rd(1, ra(OFF_LATCH1), LATCH_RESET, 1'b1);
        rd(1, ra(OFF_LATCH2), LATCH_RESET, 1'b1);
        check({p1_oe, p2_oe}, 16'h0000);
        repeat (4) begin
            pp1 = 1'($urandom);
            pp2 = 1'($urandom);
            ext1 = 8'($urandom);
            ext2 = 8'($urandom);
            lat[0] = 8'($urandom);
            lat[1] = 8'($urandom);
            acc(0, ra(OFF_LATCH1), lat[0], 1'b1);
            acc(0, ra(OFF_LATCH2), lat[1], 1'b1);
            rd(1, ra(OFF_LATCH1), lat[0], 1'b1);
            rd(1, ra(OFF_LATCH2), lat[1], 1'b1);
            rd(1, ra(OFF_PIN1), pin_exp(lat[0], pp1, ext1), 1'b1);
            rd(1, ra(OFF_PIN2), pin_exp(lat[1], pp2, ext2), 1'b1);
            check({p1, p1_oe}, {lat[0], ~lat[0] | {8{pp1}}});
            check({p2, p2_oe}, {lat[1], ~lat[1] | {8{pp2}}});
        end
        foreach (unused[i]) begin
            acc(0, ra(unused[i]), 8'h3c, 1'b1);
            acc(1, ra(unused[i]), 8'h00, 1'b1);
            check({8'h00, rdata}, {8'h00, READ_ZERO});
        end
        check({p1, p2}, {lat[0], lat[1]});
        acc(0, ra(OFF_LATCH1), ~lat[0], 1'b0);
        check({8'h00, p1}, {8'h00, lat[0]});
        acc(1, ra(OFF_LATCH1), 8'h00, 1'b0);
        check({7'h00, seen, rdata}, 16'h0000);
        rd(2, ra(OFF_LATCH1), 8'h00, 1'b0);
        rd(1, 16'h0123, 8'h00, 1'b0);
        base = 5'($urandom_range(0, 30));
        lat[1] = 8'($urandom);
        acc(0, ra(OFF_LATCH2), lat[1], 1'b1);
        rd(1, ra(OFF_LATCH2), lat[1], 1'b1);
        rd(1, 16'hf801, 8'h00, 1'b0);
        for (int pol = 0; pol < 2; pol++) begin
            rst_low = pol[0];
            rst_pin = pol[0];
            acc(0, ra(OFF_LATCH1), 8'h00, 1'b1);
            rd(1, ra(OFF_LATCH1), 8'h00, 1'b1);
            rst_pin = ~pol[0];
            repeat (2) @(negedge clk);
            rst_pin = pol[0];
            rd(1, ra(OFF_LATCH1), LATCH_RESET, 1'b1);
        end
        upper = 1'($urandom);
        foreach (codes[i]) begin
            psel = {6'($urandom), codes[i]};
            acc(0, ra(OFF_PLANE_SEL), psel, 1'b1);
            rd(1, ra(OFF_PLANE_SEL), psel, 1'b1);
            wdat = 8'($urandom);
            n = pulses;
            prog = 1'b1;
            acc(0, {upper, 15'h0123}, wdat, 1'b1);
            prog = 1'b0;
            check(16'(pulses - n), {15'h0000, codes[i] == PLANE_PROG_CONFIG});
            if (codes[i] == PLANE_PROG_CONFIG) begin
                check(cfg_addr, {upper, 15'h0123});
                check({8'h00, cfg_data}, {8'h00, wdat});
            end
            if (codes[i] == PLANE_PROG_EPROM) begin
                eprom_val = wdat;
            end
            rd(2, {upper, 15'h0123}, eprom_val, 1'b1);
        end
        rd(2, {~upper, 15'h0123}, 8'h00, 1'b0);
        single = 1'b1;
        rd(1, {upper, 15'h0123}, eprom_val, 1'b1);
        // The reset pin pulses above set the second latch back to all ones.
        rd(2, ra(OFF_LATCH2), LATCH_RESET, 1'b1);
        give_verdict();
    end
endmodule
